/* File: hdl/rcg_pkg.sv */
// Purpose: Shared constants for the remote input command gate
// Assumes: Input bit map follows the initial remote assignment
// Notes:   Unassigned functions use RCG_UNSET as their bit index
package rcg_pkg;
   localparam int RCG_IN_W        = 24;
   localparam int RCG_SEL_W       = 6;
   localparam int RCG_SYNC_STAGES = 2;
   localparam logic [4:0] RCG_UNSET = 5'h1f;
   // Default input bit positions
   localparam logic [4:0] RCG_BIT_START = 5'h00;
   localparam logic [4:0] RCG_BIT_SEL1  = 5'h01;
   localparam logic [4:0] RCG_BIT_SEL2  = 5'h02;
   localparam logic [4:0] RCG_BIT_SEL4  = 5'h03;
   localparam logic [4:0] RCG_BIT_SEL8  = 5'h1f;
   localparam logic [4:0] RCG_BIT_SEL16 = 5'h1f;
   localparam logic [4:0] RCG_BIT_SEL32 = 5'h1f;
   localparam logic [4:0] RCG_BIT_STOP  = 5'h04;
   localparam logic [4:0] RCG_BIT_PAUSE = 5'h05;
   localparam logic [4:0] RCG_BIT_CONT  = 5'h06;
   localparam logic [4:0] RCG_BIT_RESET = 5'h07;
   localparam logic [4:0] RCG_BIT_FORCE = 5'h1f;
   // Remote outputs occupy output bits 0 to 7 after reset
   localparam logic [4:0] RCG_OUT_BASE  = 5'h00;
   // Interrupt status bit positions
   localparam int RCG_EV_START  = 0;
   localparam int RCG_EV_STOP   = 1;
   localparam int RCG_EV_PAUSE  = 2;
   localparam int RCG_EV_CONT   = 3;
   localparam int RCG_EV_RESET  = 4;
   localparam int RCG_EV_FORCE  = 5;
   localparam int RCG_EV_DROP   = 6;
   localparam int RCG_EV_W      = 7;
   // Register offsets
   localparam logic [3:0] RCG_REG_CTRL   = 4'h0;
   localparam logic [3:0] RCG_REG_STAT   = 4'h1;
   localparam logic [3:0] RCG_REG_IRQ    = 4'h2;
   localparam logic [3:0] RCG_REG_MASK   = 4'h3;
   localparam logic [3:0] RCG_REG_ROUT   = 4'h4;
   localparam logic [3:0] RCG_REG_FMAP   = 4'h5;
   // Control register fields
   localparam int RCG_CTRL_ASSIGN  = 0;
   localparam int RCG_CTRL_REMSRC  = 1;
   localparam int RCG_CTRL_FPREF   = 2;
   localparam logic [7:0] RCG_CTRL_RST = 8'h00;
   localparam logic [7:0] RCG_MASK_RST = 8'h00;
   typedef enum logic [1:0] {
      RCG_FP_IDLE  = 2'b00,
      RCG_FP_HOLD  = 2'b01
   } rcg_fp_state_t;
endpackage

/* File: hdl/rcg_onset.sv */
// Purpose: Two-stage synchroniser with rising edge strobe per input
// Assumes: Inputs are asynchronous pins
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module rcg_onset (
   input  wire logic                        clk,     // System clock
   input  wire logic                        reset_n, // Async reset, low
   input  wire logic [rcg_pkg::RCG_IN_W-1:0] pin_in,  // Raw pins
   output logic      [rcg_pkg::RCG_IN_W-1:0] level,   // Synced level
   output logic      [rcg_pkg::RCG_IN_W-1:0] onset    // One-cycle rise
);
   logic [rcg_pkg::RCG_IN_W-1:0] meta;
   logic [rcg_pkg::RCG_IN_W-1:0] sync;
   logic [rcg_pkg::RCG_IN_W-1:0] prev;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta <= '0;
         sync <= '0;
         prev <= '0;
      end else begin
         meta <= pin_in;
         sync <= meta;
         prev <= sync;
      end
   end

   assign level = sync;
   assign onset = sync & ~prev;
endmodule
`default_nettype wire

/* File: hdl/rcg_gate.sv */
// Purpose: Remote input command gate: qualifies remote commands
// Assumes: Status inputs come from controller logic on clk
// Notes:   Register port: addr, wdata, wr, rd, rdata one cycle later
//
// Contract
// - Remote inputs and outputs start on general bits 0 to 7.
// - Commands need assignment and remote source; then remote-active is high.
// - Non-select inputs act on onset only if conditions hold then.
// - After an error only reset is accepted until cleared.
// - Start launches selected routine when ready, no fault, no pause/stop.
// - Six weighted select bits form the routine number.
// - Stop halts all tasks with only the general condition.
// - Pause suspends tasks only while task-executing is high.
// - Continue resumes when suspended and pause and stop low.
// - Reset clears halt and error, only while ready.
// - Forced reduced power is accepted any time.
// - While forced, run low power and reject high power requests.
// - On forced onset, stop or suspend tasks by stored preference.
// - All other commands also need remote-active high.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module rcg_gate (
   input  wire logic                          clk,            // 250 MHz clock
   input  wire logic                          reset_n,        // Async reset, low
   input  wire logic [rcg_pkg::RCG_IN_W-1:0]  gp_in,          // General input pins
   input  wire logic                          ready,          // Ready status
   input  wire logic                          task_running,   // Tasks executing
   input  wire logic                          task_paused,    // Tasks suspended
   input  wire logic                          error_active,   // Error state
   input  wire logic                          emergency_halt_active, // Halt state
   input  wire logic                          guard_open_active,     // Guard open
   input  wire logic                          high_power_req, // Power high request
   input  wire logic [3:0]                    reg_addr,       // Register address
   input  wire logic [7:0]                    reg_wdata,      // Write data
   input  wire logic                          reg_wr,         // Write strobe
   input  wire logic                          reg_rd,         // Read strobe
   output logic      [7:0]                    reg_rdata,      // Read data
   output logic                               remote_active_flag, // Remote accepted
   output logic                               cmd_start,      // Start pulse
   output logic      [rcg_pkg::RCG_SEL_W-1:0] routine_select_bits, // Routine number
   output logic                               cmd_stop,       // Stop pulse
   output logic                               cmd_pause,      // Pause pulse
   output logic                               cmd_continue,   // Continue pulse
   output logic                               cmd_reset,      // Error reset pulse
   output logic                               forced_reduced_drive, // Low power hold
   output logic                               high_power_grant, // Power high allowed
   output logic                               irq             // Interrupt level
);
   logic [rcg_pkg::RCG_IN_W-1:0] lvl;
   logic [rcg_pkg::RCG_IN_W-1:0] ons;
   logic [7:0]                   ctrl;
   logic [7:0]                   mask;
   logic [rcg_pkg::RCG_EV_W-1:0] irq_stat;
   logic [rcg_pkg::RCG_EV_W-1:0] ev;
   rcg_pkg::rcg_fp_state_t       fp_state;
   rcg_pkg::rcg_fp_state_t       next_fp_state;
   logic                         rem_ok;
   logic                         fault;
   logic                         ok_start;
   logic                         ok_stop;
   logic                         ok_pause;
   logic                         ok_cont;
   logic                         ok_reset;
   logic                         on_start;
   logic                         on_stop;
   logic                         on_pause;
   logic                         on_cont;
   logic                         on_reset;
   logic                         on_force;
   logic                         in_pause;
   logic                         in_stop;
   logic                         in_force;
   logic                         dropped;
   logic [4:0]                   force_bit;

   // Pick one mapped bit; unassigned reads as low
   function automatic logic pick(input logic [rcg_pkg::RCG_IN_W-1:0] v,
                                 input logic [4:0] idx);
      pick = (idx == rcg_pkg::RCG_UNSET || idx >= 5'(rcg_pkg::RCG_IN_W)) ? 1'b0 : v[idx];
   endfunction

   rcg_onset u_onset (
      .clk     (clk),
      .reset_n (reset_n),
      .pin_in  (gp_in),
      .level   (lvl),
      .onset   (ons)
   );

   // Default map on bits 0 to 7
   assign on_start = pick(ons, rcg_pkg::RCG_BIT_START);
   assign on_stop  = pick(ons, rcg_pkg::RCG_BIT_STOP);
   assign on_pause = pick(ons, rcg_pkg::RCG_BIT_PAUSE);
   assign on_cont  = pick(ons, rcg_pkg::RCG_BIT_CONT);
   assign on_reset = pick(ons, rcg_pkg::RCG_BIT_RESET);
   // Forced input bit is software mapped, unset after reset
   assign on_force = pick(ons, force_bit);
   assign in_pause = pick(lvl, rcg_pkg::RCG_BIT_PAUSE);
   assign in_stop  = pick(lvl, rcg_pkg::RCG_BIT_STOP);
   assign in_force = pick(lvl, force_bit);

   // Remote source gate
   assign rem_ok = ctrl[rcg_pkg::RCG_CTRL_ASSIGN] & ctrl[rcg_pkg::RCG_CTRL_REMSRC];
   assign fault  = error_active;

   // Commands wait for the remote-active output itself
   assign ok_start = remote_active_flag & ~fault & ready & ~emergency_halt_active
                     & ~guard_open_active & ~in_pause & ~in_stop;
   assign ok_stop  = remote_active_flag & ~fault;
   assign ok_pause = remote_active_flag & ~fault & task_running;
   assign ok_cont  = remote_active_flag & ~fault & task_paused & ~in_pause
                     & ~in_stop;
   assign ok_reset = remote_active_flag & ready;

   // Unqualified onsets counted as dropped
   assign dropped = (on_start & ~ok_start) | (on_stop & ~ok_stop) | (on_pause & ~ok_pause)
                    | (on_cont & ~ok_cont) | (on_reset & ~ok_reset);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         remote_active_flag <= 1'b0;
      end else begin
         remote_active_flag <= rem_ok;
      end
   end

   // Command pulses act on onset only, never pending
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_start    <= 1'b0;
         cmd_pause    <= 1'b0;
         cmd_continue <= 1'b0;
         cmd_reset    <= 1'b0;
      end else begin
         cmd_start    <= on_start & ok_start;
         cmd_pause    <= (on_pause & ok_pause)
                         | (on_force & ctrl[rcg_pkg::RCG_CTRL_FPREF]);
         cmd_continue <= on_cont & ok_cont;
         cmd_reset    <= on_reset & ok_reset;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_stop <= 1'b0;
      end else begin
         cmd_stop <= (on_stop & ok_stop)
                     | (on_force & ~ctrl[rcg_pkg::RCG_CTRL_FPREF]);
      end
   end

   // Routine number latched with start
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         routine_select_bits <= '0;
      end else if (on_start & ok_start) begin
         routine_select_bits <= {pick(lvl, rcg_pkg::RCG_BIT_SEL32),
                                 pick(lvl, rcg_pkg::RCG_BIT_SEL16),
                                 pick(lvl, rcg_pkg::RCG_BIT_SEL8),
                                 pick(lvl, rcg_pkg::RCG_BIT_SEL4),
                                 pick(lvl, rcg_pkg::RCG_BIT_SEL2),
                                 pick(lvl, rcg_pkg::RCG_BIT_SEL1)};
      end
   end

   // Forced reduced power, no remote gate
   always_comb begin
      unique case (fp_state)
         rcg_pkg::RCG_FP_IDLE: next_fp_state = in_force ? rcg_pkg::RCG_FP_HOLD
                                                         : rcg_pkg::RCG_FP_IDLE;
         rcg_pkg::RCG_FP_HOLD: next_fp_state = in_force ? rcg_pkg::RCG_FP_HOLD
                                                         : rcg_pkg::RCG_FP_IDLE;
         default:              next_fp_state = rcg_pkg::RCG_FP_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fp_state <= rcg_pkg::RCG_FP_IDLE;
      end else begin
         fp_state <= next_fp_state;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         forced_reduced_drive <= 1'b0;
         high_power_grant     <= 1'b0;
      end else begin
         forced_reduced_drive <= (next_fp_state == rcg_pkg::RCG_FP_HOLD);
         high_power_grant     <= high_power_req & ~in_force;
      end
   end

   // Events for interrupt status
   always_comb begin
      ev = '0;
      ev[rcg_pkg::RCG_EV_START] = on_start & ok_start;
      ev[rcg_pkg::RCG_EV_STOP]  = on_stop & ok_stop;
      ev[rcg_pkg::RCG_EV_PAUSE] = on_pause & ok_pause;
      ev[rcg_pkg::RCG_EV_CONT]  = on_cont & ok_cont;
      ev[rcg_pkg::RCG_EV_RESET] = on_reset & ok_reset;
      ev[rcg_pkg::RCG_EV_FORCE] = on_force;
      ev[rcg_pkg::RCG_EV_DROP]  = dropped;
   end

   // Control and mask registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= rcg_pkg::RCG_CTRL_RST;
         mask <= rcg_pkg::RCG_MASK_RST;
         force_bit <= rcg_pkg::RCG_BIT_FORCE;
      end else if (reg_wr) begin
         if (reg_addr == rcg_pkg::RCG_REG_CTRL) begin
            ctrl <= reg_wdata;
         end
         if (reg_addr == rcg_pkg::RCG_REG_MASK) begin
            mask <= reg_wdata;
         end
         if (reg_addr == rcg_pkg::RCG_REG_FMAP) begin
            force_bit <= reg_wdata[4:0];
         end
      end
   end

   // Sticky status, set wins over write-one-clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= (irq_stat & ~((reg_wr && reg_addr == rcg_pkg::RCG_REG_IRQ)
                                   ? reg_wdata[rcg_pkg::RCG_EV_W-1:0] : '0)) | ev;
      end
   end

   assign irq = |(irq_stat & mask[rcg_pkg::RCG_EV_W-1:0]);

   // Read data one cycle after strobe
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            rcg_pkg::RCG_REG_CTRL: reg_rdata <= ctrl;
            rcg_pkg::RCG_REG_STAT: reg_rdata <= {1'b0, in_force, error_active,
                                                 emergency_halt_active, guard_open_active,
                                                 task_paused, task_running,
                                                 remote_active_flag};
            rcg_pkg::RCG_REG_IRQ:  reg_rdata <= {1'b0, irq_stat};
            rcg_pkg::RCG_REG_MASK: reg_rdata <= mask;
            rcg_pkg::RCG_REG_ROUT: reg_rdata <= {3'h0, rcg_pkg::RCG_OUT_BASE};
            rcg_pkg::RCG_REG_FMAP: reg_rdata <= {3'h0, force_bit};
            default:               reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule
`default_nettype wire

/* File: dv/rcg_gate_chk.sv */
// Purpose: Port level checks for rcg_gate
// Assumes: Default input map, one clock
// Notes:   Bound to rcg_gate below
`timescale 1ns/10ps
`default_nettype none
module rcg_gate_chk (
   input wire logic       clk,                   // Clock
   input wire logic       reset_n,               // Reset, low
   input wire logic       ready,                 // Ready
   input wire logic       task_running,          // Running
   input wire logic       task_paused,           // Paused
   input wire logic       error_active,          // Error
   input wire logic       emergency_halt_active, // Halt
   input wire logic       guard_open_active,     // Guard
   input wire logic [3:0] reg_addr,              // Address
   input wire logic       reg_wr,                // Write
   input wire logic       remote_active_flag,    // Remote
   input wire logic       cmd_start,             // Start
   input wire logic       cmd_stop,              // Stop
   input wire logic       cmd_pause,             // Pause
   input wire logic       cmd_continue,          // Continue
   input wire logic       cmd_reset,             // Reset
   input wire logic       forced_reduced_drive,  // Forced
   input wire logic       high_power_grant       // Grant
);
   wire logic [4:0] cmds = {cmd_reset, cmd_continue, cmd_pause, cmd_stop, cmd_start};
   wire logic       ctrl_wr = reg_wr && reg_addr == rcg_pkg::RCG_REG_CTRL;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   start_gate_a: assert property (cmd_start |-> $past(ready && remote_active_flag
      && !emergency_halt_active && !guard_open_active)) else $error("start not allowed");
   err_block_a: assert property ((cmd_start || cmd_continue) |-> !$past(error_active))
      else $error("command during error");
   pause_gate_a: assert property (cmd_pause |-> forced_reduced_drive
      || $past(task_running && remote_active_flag)) else $error("pause not allowed");
   cont_gate_a: assert property (cmd_continue |-> $past(task_paused && remote_active_flag))
      else $error("continue not allowed");
   reset_gate_a: assert property (cmd_reset |-> $past(ready && remote_active_flag))
      else $error("reset not allowed");
   stop_gate_a: assert property (cmd_stop |-> forced_reduced_drive || $past(remote_active_flag))
      else $error("stop while remote idle");
   one_cycle_a: assert property ((cmds & $past(cmds)) == 5'h00)
      else $error("command pulse too long");
   remote_src_a: assert property ($rose(remote_active_flag) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
      else $error("remote active without write");
   low_power_a: assert property (forced_reduced_drive |-> !high_power_grant)
      else $error("high power while forced");
endmodule
bind rcg_gate rcg_gate_chk chk (.clk(clk), .reset_n(reset_n), .ready(ready),
   .task_running(task_running), .task_paused(task_paused), .error_active(error_active),
   .emergency_halt_active(emergency_halt_active), .guard_open_active(guard_open_active),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .remote_active_flag(remote_active_flag),
   .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_pause(cmd_pause),
   .cmd_continue(cmd_continue), .cmd_reset(cmd_reset),
   .forced_reduced_drive(forced_reduced_drive), .high_power_grant(high_power_grant));
`default_nettype wire

/* File: dv/rcg_seq_model.sv */
// Purpose: Sequencer side that drives the remote input pins
// Assumes: Pins high means on, unused pins held low
// Notes:   Pins change just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module rcg_seq_model (
   input  wire logic        clk,          // Clock
   input  wire logic        error_active, // Error seen
   output var  logic [23:0] gp_in         // Remote pins
);
   initial gp_in = 24'h000000;
   task automatic set_pin(input int b, input logic v);
      @(posedge clk);
      gp_in[b] <= v;
   endtask
   // Long enough for the synchroniser, then low before reuse
   task automatic press(input int b);
      set_pin(b, 1'b1);
      repeat (8) @(posedge clk);
      gp_in[b] <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic clear_error;
      if (error_active) press(7);
   endtask
endmodule
`default_nettype wire

/* File: dv/rcg_gate_test.sv */
// Purpose: Self checking bench for rcg_gate
// Assumes: Default input map, status inputs driven here
// Notes:   Commands collected over a fixed window
`timescale 1ns/10ps
`default_nettype none
module rcg_gate_test;
   logic        clk, reset_n, ready, task_running, task_paused, error_active;
   logic        emergency_halt_active, guard_open_active, high_power_req, reg_wr, reg_rd;
   logic        remote_active_flag, cmd_start, cmd_stop, cmd_pause, cmd_continue, cmd_reset;
   logic        forced_reduced_drive, high_power_grant, irq;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, rv;
   logic [23:0] gp_in;
   logic [5:0]  routine_select_bits;
   logic [4:0]  seen;
   int          n_fail, checks, cyc;
   wire logic [4:0] cmds = {cmd_reset, cmd_continue, cmd_pause, cmd_stop, cmd_start};
   rcg_seq_model seq (.clk(clk), .error_active(error_active), .gp_in(gp_in));
   rcg_gate dut (.clk(clk), .reset_n(reset_n), .gp_in(gp_in), .ready(ready),
      .task_running(task_running), .task_paused(task_paused), .error_active(error_active),
      .emergency_halt_active(emergency_halt_active), .guard_open_active(guard_open_active),
      .high_power_req(high_power_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .remote_active_flag(remote_active_flag), .cmd_start(cmd_start),
      .routine_select_bits(routine_select_bits), .cmd_stop(cmd_stop), .cmd_pause(cmd_pause),
      .cmd_continue(cmd_continue), .cmd_reset(cmd_reset),
      .forced_reduced_drive(forced_reduced_drive), .high_power_grant(high_power_grant),
      .irq(irq));
   always #2 clk = ~clk;
   task automatic report_and_stop;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
      @(posedge clk);
   endtask
   // Press pin b (none if negative; pin 7 only while error_active) and gather command pulses
   task automatic fire(input int b, input logic [4:0] exp);
      seen = 5'h00;
      fork
         if (b == 7) seq.clear_error();
         else if (b >= 0) seq.press(b);
         repeat (13) begin
            @(posedge clk);
            #1;
            seen = seen | cmds;
         end
      join
      @(posedge clk);
      chk({3'h0, seen}, {3'h0, exp});
   endtask
   initial begin
      {clk, reset_n, ready, task_running, task_paused, error_active} = 6'h00;
      {emergency_halt_active, guard_open_active, high_power_req, reg_wr, reg_rd} = 5'h00;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      rd(rcg_pkg::RCG_REG_CTRL, rcg_pkg::RCG_CTRL_RST);
      rd(rcg_pkg::RCG_REG_MASK, rcg_pkg::RCG_MASK_RST);
      rd(4'hf, 8'h00);
      ready <= 1'b1;
      fire(0, 5'h00);
      wr(rcg_pkg::RCG_REG_CTRL, 8'h03);
      wr(rcg_pkg::RCG_REG_IRQ, 8'h7f);
      chk({7'h0, remote_active_flag}, 8'h01);
      rd(rcg_pkg::RCG_REG_STAT, 8'h01);
      guard_open_active <= 1'b1;
      fire(0, 5'h00);
      guard_open_active <= 1'b0;
      fire(-1, 5'h00);
      rd(rcg_pkg::RCG_REG_IRQ, 8'h40);
      seq.set_pin(4, 1'b1);
      fire(-1, 5'h02);
      fire(0, 5'h00);
      seq.set_pin(4, 1'b0);
      wr(rcg_pkg::RCG_REG_IRQ, 8'h7f);
      seq.set_pin(1, 1'b1);
      seq.set_pin(3, 1'b1);
      fire(0, 5'h01);
      chk({2'h0, routine_select_bits}, 8'h05);
      chk({7'h0, irq}, 8'h00);
      wr(rcg_pkg::RCG_REG_MASK, 8'h01);
      chk({7'h0, irq}, 8'h01);
      rd(rcg_pkg::RCG_REG_IRQ, 8'h01);
      wr(rcg_pkg::RCG_REG_IRQ, 8'h01);
      chk({7'h0, irq}, 8'h00);
      fire(5, 5'h00);
      task_running <= 1'b1;
      fire(5, 5'h04);
      task_paused <= 1'b1;
      seq.set_pin(5, 1'b1);
      fire(6, 5'h04);
      seq.set_pin(5, 1'b0);
      fire(6, 5'h08);
      error_active <= 1'b1;
      fire(0, 5'h00);
      ready <= 1'b0;
      fire(7, 5'h00);
      ready <= 1'b1;
      fire(7, 5'h10);
      error_active <= 1'b0;
      high_power_req <= 1'b1;
      repeat (3) @(posedge clk);
      chk({6'h0, forced_reduced_drive, high_power_grant}, 8'h01);
      rd(rcg_pkg::RCG_REG_ROUT, 8'h00);
      // Map forced power to pin 8, remote off, pause preference
      wr(rcg_pkg::RCG_REG_FMAP, 8'h08);
      wr(rcg_pkg::RCG_REG_CTRL, 8'h04);
      fire(8, 5'h04);
      wr(rcg_pkg::RCG_REG_CTRL, 8'h00);
      fire(8, 5'h02);
      seq.set_pin(8, 1'b1);
      repeat (4) @(posedge clk);
      chk({6'h0, forced_reduced_drive, high_power_grant}, 8'h02);
      rd(rcg_pkg::RCG_REG_STAT, 8'h46);
      seq.set_pin(8, 1'b0);
      report_and_stop();
   end
endmodule
`default_nettype wire
